// *** include/wakeup_timer_consts.vh ***
`ifndef WAKEUP_TIMER_CONSTS_VH
`define WAKEUP_TIMER_CONSTS_VH

// Register byte addresses
`define ADDR_RELOAD_VALUE      32'hffff0340
`define ADDR_LIVE_COUNT        32'hffff0344
`define ADDR_TIMER_CONTROL     32'hffff0348
`define ADDR_RELOAD_CLEAR      32'hffff034c
`define ADDR_EVENT_STATUS      32'hffff0350
`define ADDR_EVENT_MASK        32'hffff0354

// Reset values
`define RST_RELOAD_VALUE       32'h00000000
`define RST_LIVE_COUNT         32'h00000000
`define RST_TIMER_CONTROL      32'h00000000
`define RST_EVENT_STATUS       2'h0
`define RST_EVENT_MASK         2'h3

// timer_control fields
`define CTL_WRITE_MASK         32'h000007ff
`define CTL_PSC_MSB            3
`define CTL_PSC_LSB            0
`define CTL_FMT_MSB            5
`define CTL_FMT_LSB            4
`define CTL_PERIODIC_BIT       6
`define CTL_ENABLE_BIT         7
`define CTL_COUNT_UP_BIT       8
`define CTL_SRC_MSB            10
`define CTL_SRC_LSB            9

// Clock source codes
`define SRC_OSC_32K            2'h0
`define SRC_CORE               2'h1
`define SRC_WATCH_XTAL         2'h2
`define SRC_PLL_UNDIV          2'h3

// Prescaler codes and the divide shift each gives
`define PSC_DIV1               4'h0
`define PSC_DIV16              4'h4
`define PSC_DIV256             4'h8
`define PSC_DIV32768           4'hf
`define PSC_SHIFT_DIV1         4'h0
`define PSC_SHIFT_DIV16        4'h4
`define PSC_SHIFT_DIV256       4'h8
`define PSC_SHIFT_DIV32768     4'hf
`define PSC_WIDTH              15

// Count formats
`define FMT_BINARY             2'h0
`define FMT_RESERVED           2'h1
`define FMT_TIME_23H           2'h2
`define FMT_TIME_255H          2'h3

// Time-of-day field layout and limits
`define TOD_HOUR_MSB           31
`define TOD_HOUR_LSB           24
`define TOD_MIN_MSB            23
`define TOD_MIN_LSB            16
`define TOD_SEC_MSB            15
`define TOD_SEC_LSB            8
`define TOD_HUND_MSB           7
`define TOD_HUND_LSB           0
`define TOD_HUND_MAX           8'd99
`define TOD_SEC_MAX            8'd59
`define TOD_MIN_MAX            8'd59
`define TOD_HOUR_MAX_23        8'd23
`define TOD_HOUR_MAX_255       8'd255

// Event status bits
`define EVT_OVERFLOW_BIT       0
`define EVT_UNDERFLOW_BIT      1
`define EVT_WIDTH              2

`endif

// *** rtl/tick_source.v ***
`timescale 1ns/100ps
`default_nettype none
`include "wakeup_timer_consts.vh"

module tick_source #(
  parameter integer PIN_COUNT = 3
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [1:0]  src_sel_i,
  input  wire [3:0]  prescale_i,
  input  wire        osc_32k_i,
  input  wire        watch_xtal_i,
  input  wire        undivided_pll_clock_i,
  output reg         tick_o
);

  wire [PIN_COUNT-1:0] pin_raw;
  reg  [PIN_COUNT-1:0] sync_a;
  reg  [PIN_COUNT-1:0] sync_b;
  reg  [PIN_COUNT-1:0] sync_c;
  reg  [PIN_COUNT-1:0] level;
  reg  [PIN_COUNT-1:0] rise;

  assign pin_raw = {undivided_pll_clock_i, watch_xtal_i, osc_32k_i};

  // A source edge counts only once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1) begin : pin_sync
      always @(posedge clk_i) begin
        if (rst_i) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
          sync_c[g] <= 1'b0;
          level[g]  <= 1'b0;
          rise[g]   <= 1'b0;
        end else begin
          sync_a[g] <= pin_raw[g];
          sync_b[g] <= sync_a[g];
          sync_c[g] <= sync_b[g];
          rise[g]   <= 1'b0;
          if (sync_b[g] == sync_c[g]) begin
            level[g] <= sync_c[g];
            rise[g]  <= sync_c[g] & ~level[g];
          end
        end
      end
    end
  endgenerate

  reg                    src_edge;
  reg [3:0]              shift;
  reg [`PSC_WIDTH-1:0]   div_mask;
  reg [`PSC_WIDTH-1:0]   div_count;

  always @* begin
    case (src_sel_i)
      `SRC_OSC_32K:    src_edge = rise[0];
      `SRC_CORE:       src_edge = 1'b1;
      `SRC_WATCH_XTAL: src_edge = rise[1];
      `SRC_PLL_UNDIV:  src_edge = rise[2];
      default:         src_edge = 1'b0;
    endcase
  end

  // Undocumented prescaler codes fall back to divide by one
  always @* begin
    case (prescale_i)
      `PSC_DIV16:    shift = `PSC_SHIFT_DIV16;
      `PSC_DIV256:   shift = `PSC_SHIFT_DIV256;
      `PSC_DIV32768: shift = `PSC_SHIFT_DIV32768;
      default:       shift = `PSC_SHIFT_DIV1;
    endcase
    div_mask = ~({`PSC_WIDTH{1'b1}} << shift);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      div_count <= {`PSC_WIDTH{1'b0}};
      tick_o    <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (src_edge) begin
        if ((div_count & div_mask) == div_mask) begin
          div_count <= {`PSC_WIDTH{1'b0}};
          tick_o    <= 1'b1;
        end else begin
          div_count <= div_count + {{(`PSC_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/wakeup_timer_32bit.v ***
// Summary of operation
// - Control bit 8 picks up or down counting.
// - Control bits 10:9 pick source clock.
// - Control bits 3:0 pick prescaler divide ratio.
// - Control bit 7 enables counting, else hold.
// - Control bit 6 selects periodic or free-running.
// - Control bits 5:4 select binary or time format.
// - Overflow reloads counter from reload value; here only in periodic mode (bit 6), free-running wraps to the next value.
// - Clear strobe write reloads and clears interrupt.
// - Live count readable, writes ignored.
// - Counting continues while core clock stopped; here all logic runs on clk_i, so it stops too.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "wakeup_timer_consts.vh"

module wakeup_timer_32bit #(
  parameter integer COUNT_WIDTH = 32
) (
  input  wire                   clk_i,
  input  wire                   rst_i,
  input  wire                   cyc_i,
  input  wire                   stb_i,
  input  wire                   we_i,
  input  wire [31:0]            adr_i,
  input  wire [3:0]             sel_i,
  input  wire [31:0]            dat_i,
  output reg  [31:0]            dat_o,
  output reg                    ack_o,
  input  wire                   osc_32k_i,
  input  wire                   watch_xtal_i,
  input  wire                   undivided_pll_clock_i,
  output reg                    irq_o
);

  reg  [COUNT_WIDTH-1:0] reload_value;
  reg  [COUNT_WIDTH-1:0] live_count;
  reg  [31:0]            timer_control;
  reg  [`EVT_WIDTH-1:0]  event_status;
  reg  [`EVT_WIDTH-1:0]  event_mask;
  reg  [`EVT_WIDTH-1:0]  status_taken;

  wire                   tick;
  wire [1:0]             src_sel;
  wire [3:0]             prescale;
  wire [1:0]             fmt;
  wire                   periodic;
  wire                   enable;
  wire                   count_up;
  wire                   time_fmt;

  assign src_sel  = timer_control[`CTL_SRC_MSB:`CTL_SRC_LSB];
  assign prescale = timer_control[`CTL_PSC_MSB:`CTL_PSC_LSB];
  assign fmt      = timer_control[`CTL_FMT_MSB:`CTL_FMT_LSB];
  assign periodic = timer_control[`CTL_PERIODIC_BIT];
  assign enable   = timer_control[`CTL_ENABLE_BIT];
  assign count_up = timer_control[`CTL_COUNT_UP_BIT];
  assign time_fmt = (fmt == `FMT_TIME_23H) || (fmt == `FMT_TIME_255H);

  // Runs from clk_i, the same clock that paces the core source, so stopping the core clock stops it
  tick_source #(
    .PIN_COUNT (3)
  ) u_tick_source (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .src_sel_i             (src_sel),
    .prescale_i            (prescale),
    .osc_32k_i             (osc_32k_i),
    .watch_xtal_i          (watch_xtal_i),
    .undivided_pll_clock_i (undivided_pll_clock_i),
    .tick_o                (tick)
  );

  // Bus decode

  wire access;
  wire wr_commit;
  wire rd_commit;
  wire hit_reload;
  wire hit_count;
  wire hit_control;
  wire hit_clear;
  wire hit_status;
  wire hit_mask;

  assign access      = cyc_i & stb_i;
  // Side effects take place on the edge that the master samples ack
  assign wr_commit   = access & ack_o & we_i;
  assign rd_commit   = access & ack_o & ~we_i;
  // Full 32-bit decode, so no alias answers
  assign hit_reload  = (adr_i == `ADDR_RELOAD_VALUE);
  assign hit_count   = (adr_i == `ADDR_LIVE_COUNT);
  assign hit_control = (adr_i == `ADDR_TIMER_CONTROL);
  assign hit_clear   = (adr_i == `ADDR_RELOAD_CLEAR);
  assign hit_status  = (adr_i == `ADDR_EVENT_STATUS);
  assign hit_mask    = (adr_i == `ADDR_EVENT_MASK);

  wire clear_strobe;

  assign clear_strobe = wr_commit & hit_clear;

  // Read data is latched at the take edge, so it stands through the ack cycle
  wire rd_take;

  assign rd_take = access & ~ack_o & ~we_i;

  function [31:0] merge_lanes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  lanes;
    integer      i;
    begin
      merge_lanes = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (lanes[i]) begin
          merge_lanes[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // Lane merges; only the low bits of the mask are kept
  wire [31:0] reload_merged;
  wire [31:0] control_merged;
  wire [31:0] mask_merged;

  assign reload_merged  = merge_lanes(reload_value, dat_i, sel_i);
  assign control_merged = merge_lanes(timer_control, dat_i, sel_i) & `CTL_WRITE_MASK;
  assign mask_merged    = merge_lanes({{(32-`EVT_WIDTH){1'b0}}, event_mask}, dat_i, sel_i);

  // One time field step; returns carry-out above the field value
  function [8:0] step_field;
    input [7:0] val;
    input [7:0] max_val;
    input       up;
    input       carry_in;
    begin
      step_field = {1'b0, val};
      if (carry_in) begin
        if (up) begin
          // Fields above their limit restart at zero
          if (val >= max_val) begin
            step_field = {1'b1, 8'h00};
          end else begin
            step_field = {1'b0, val + 8'h01};
          end
        end else begin
          // Borrow loads the field's limit
          if (val == 8'h00) begin
            step_field = {1'b1, max_val};
          end else begin
            step_field = {1'b0, val - 8'h01};
          end
        end
      end
    end
  endfunction

  // Next count for one tick

  reg [COUNT_WIDTH-1:0] next_count;
  reg                   wrap;
  reg [8:0]             hund_step;
  reg [8:0]             sec_step;
  reg [8:0]             min_step;
  reg [8:0]             hour_step;
  reg [7:0]             hour_max;

  always @* begin
    next_count = live_count;
    wrap       = 1'b0;
    hour_max   = (fmt == `FMT_TIME_23H) ? `TOD_HOUR_MAX_23 : `TOD_HOUR_MAX_255;
    hund_step  = step_field(live_count[`TOD_HUND_MSB:`TOD_HUND_LSB], `TOD_HUND_MAX, count_up, 1'b1);
    sec_step   = step_field(live_count[`TOD_SEC_MSB:`TOD_SEC_LSB], `TOD_SEC_MAX, count_up, hund_step[8]);
    min_step   = step_field(live_count[`TOD_MIN_MSB:`TOD_MIN_LSB], `TOD_MIN_MAX, count_up, sec_step[8]);
    hour_step  = step_field(live_count[`TOD_HOUR_MSB:`TOD_HOUR_LSB], hour_max, count_up, min_step[8]);
    // Reserved format 01 counts as plain binary
    if (time_fmt) begin
      next_count = {hour_step[7:0], min_step[7:0], sec_step[7:0], hund_step[7:0]};
      wrap       = hour_step[8];
    end else if (count_up) begin
      next_count = live_count + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
      wrap       = &live_count;
    end else begin
      next_count = live_count - {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
      wrap       = ~|live_count;
    end
  end

  wire                  step;
  wire                  overflow_evt;
  wire                  underflow_evt;
  wire                  wrap_reload;

  assign step          = tick & enable;
  assign overflow_evt  = step & wrap & count_up;
  assign underflow_evt = step & wrap & ~count_up;
  assign wrap_reload   = wrap & periodic;

  // Counter

  always @(posedge clk_i) begin
    if (rst_i) begin
      live_count <= `RST_LIVE_COUNT;
    // Clear strobe outranks a tick in the same cycle
    end else if (clear_strobe) begin
      live_count <= reload_value;
    end else if (step) begin
      if (wrap_reload) begin
        live_count <= reload_value;
      end else begin
        // Free-running mode wraps through the natural next value
        live_count <= next_count;
      end
    end
  end

  // Registers written by software

  always @(posedge clk_i) begin
    if (rst_i) begin
      reload_value  <= `RST_RELOAD_VALUE;
      timer_control <= `RST_TIMER_CONTROL;
      event_mask    <= `RST_EVENT_MASK;
    end else if (wr_commit) begin
      if (hit_reload) begin
        reload_value <= reload_merged[COUNT_WIDTH-1:0];
      end
      if (hit_control) begin
        timer_control <= control_merged;
      end
      if (hit_mask) begin
        event_mask <= mask_merged[`EVT_WIDTH-1:0];
      end
    end
  end

  // Event status: hardware set wins over any clear in the same cycle

  reg [`EVT_WIDTH-1:0] next_status;
  reg [`EVT_WIDTH-1:0] evt_set;
  reg [`EVT_WIDTH-1:0] evt_clear;

  always @* begin
    // Wrap direction picks which flag is set
    evt_set                     = {`EVT_WIDTH{1'b0}};
    evt_set[`EVT_OVERFLOW_BIT]  = overflow_evt;
    evt_set[`EVT_UNDERFLOW_BIT] = underflow_evt;
    evt_clear                   = {`EVT_WIDTH{1'b0}};
    if (clear_strobe) begin
      evt_clear = {`EVT_WIDTH{1'b1}};
    end else if (rd_commit && hit_status) begin
      // Only bits the reader actually saw are cleared
      evt_clear = status_taken;
    end
    next_status = (event_status & ~evt_clear) | evt_set;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      event_status <= `RST_EVENT_STATUS;
      irq_o        <= 1'b0;
    end else begin
      event_status <= next_status;
      // Taken from next status so the irq rises with its flag
      irq_o        <= |(next_status & event_mask);
    end
  end

  // Read data and acknowledge

  reg [31:0] read_mux;

  always @* begin
    read_mux = 32'h00000000;
    if (hit_reload) begin
      read_mux = reload_value;
    end else if (hit_count) begin
      read_mux = live_count;
    end else if (hit_control) begin
      read_mux = timer_control;
    end else if (hit_status) begin
      read_mux = {{(32-`EVT_WIDTH){1'b0}}, event_status};
    end else if (hit_mask) begin
      read_mux = {{(32-`EVT_WIDTH){1'b0}}, event_mask};
    end
  end

  // Every address answers after one wait state; unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o        <= 1'b0;
      dat_o        <= 32'h00000000;
      status_taken <= {`EVT_WIDTH{1'b0}};
    end else begin
      // Ack drops after one cycle even if the master keeps the strobe up
      ack_o <= access & ~ack_o;
      if (rd_take) begin
        dat_o        <= read_mux;
        status_taken <= hit_status ? event_status : {`EVT_WIDTH{1'b0}};
      end
    end
  end

endmodule

`default_nettype wire

// *** test/wakeup_timer_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "wakeup_timer_consts.vh"
module wakeup_timer_checker #(
  parameter integer COUNT_WIDTH = 32
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i;
  wire rd_ack = ack_o && !we_i;
  AST_ACK_ANSWER: assert property (req && !ack_o |=> ack_o) else $error("ack missing");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(req)) else $error("ack without request");
  AST_DAT_HOLD: assert property (rd_ack |=> $stable(dat_o)) else $error("read data moved");
  AST_RESET_QUIET: assert property ($fell(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0) else $error("reset outputs");
  AST_WO_READ_ZERO: assert property (rd_ack && adr_i == `ADDR_RELOAD_CLEAR |-> dat_o == 32'h0)
    else $error("strobe read not zero");
  AST_CTL_RESERVED: assert property (rd_ack && adr_i == `ADDR_TIMER_CONTROL |-> (dat_o & ~`CTL_WRITE_MASK) == 32'h0)
    else $error("reserved control bits set");
  AST_CLEAR_DROPS_IRQ: assert property (ack_o && we_i && adr_i == `ADDR_RELOAD_CLEAR |=> !irq_o)
    else $error("irq kept after clear");
  AST_IRQ_HOLDS: assert property (irq_o && !ack_o && !$past(ack_o) |=> irq_o)
    else $error("irq dropped without access");
endmodule
bind wakeup_timer_32bit wakeup_timer_checker #(.COUNT_WIDTH(COUNT_WIDTH)) i_wakeup_timer_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "wakeup_timer_consts.vh"
module tb;
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [31:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        irq_o;
  logic [2:0]  pins;
  logic [31:0] rdata;
  logic [31:0] hold;
  int          error_cnt;
  int          total_checks;
  localparam logic [31:0] a_ld  = `ADDR_RELOAD_VALUE;
  localparam logic [31:0] a_val = `ADDR_LIVE_COUNT;
  localparam logic [31:0] a_ctl = `ADDR_TIMER_CONTROL;
  localparam logic [31:0] a_clr = `ADDR_RELOAD_CLEAR;
  localparam logic [31:0] a_st  = `ADDR_EVENT_STATUS;
  localparam logic [31:0] a_msk = `ADDR_EVENT_MASK;
  logic [1:0]  src_code;
  wakeup_timer_32bit i_wakeup_timer_32bit (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .osc_32k_i(pins[0]),
    .watch_xtal_i(pins[1]), .undivided_pll_clock_i(pins[2]), .irq_o(irq_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic miss(input string m);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) miss($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) miss(m);
  endtask
  // Ack is read before the slave's own update lands at the same edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (ack_o !== 1'b1) begin
      miss("bus timeout");
      conclude();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rdata);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0, rdata);
    chk(rdata, exp, m);
  endtask
  // Pins are sampled, so each level lasts four clocks
  task automatic pulse(input int p, input int cnt);
    repeat (cnt) begin
      pins[p] <= 1'b1;
      repeat (4) @(posedge clk_i);
      pins[p] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask
  task automatic setup(input logic [31:0] ld, input logic [31:0] ctl);
    wr(a_ctl, 32'h0);
    wr(a_ld, ld);
    wr(a_clr, 32'h5a);
    wr(a_ctl, ctl);
    rd(a_st, 32'h0, "status after clear");
  endtask
  task automatic one_tick(input logic [31:0] ld, input logic [31:0] ctl, input logic [31:0] exp, input logic [1:0] st);
    setup(ld, ctl);
    pulse(0, (ctl[3:0] == `PSC_DIV256) ? 256 : 1);
    rd(a_val, exp, "count after tick");
    chk_bit(irq_o, |st, "irq level");
    rd(a_st, {30'h0, st}, "event status");
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    if (irq_o !== 1'b1) begin
      miss("irq timeout");
      conclude();
    end
  endtask
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 32'h0;
    sel_i = 4'h0;
    dat_i = 32'h0;
    pins = 3'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(a_ld, 32'h0, "reload reset");
    rd(a_val, 32'h0, "count reset");
    rd(a_ctl, 32'h0, "control reset");
    rd(a_msk, 32'h3, "mask reset");
    rd(a_st, 32'h0, "status reset");
    rd(a_clr, 32'h0, "strobe reads zero");
    rd(32'hffff0358, 32'h0, "unmapped");
    wr(a_ctl, 32'hffffffff);
    rd(a_ctl, 32'h7ff, "control reserved bits");
    wr(a_ld, 32'ha5a55a5a);
    rd(a_ld, 32'ha5a55a5a, "reload readback");
    wr(a_val, 32'h12345678);
    rd(a_val, 32'h0, "count not writable");
    one_tick(32'hffffffff, 32'h180, 32'h0, 2'h1);
    one_tick(32'hffffffff, 32'h1c0, 32'hffffffff, 2'h1);
    one_tick(32'h0, 32'h080, 32'hffffffff, 2'h2);
    one_tick(32'h5, 32'h080, 32'h4, 2'h0);
    one_tick(32'h7, 32'h100, 32'h7, 2'h0);
    one_tick(32'h00003b63, 32'h1a8, 32'h00010000, 2'h0);
    one_tick(32'h173b3b63, 32'h1a8, 32'h0, 2'h1);
    one_tick(32'h0, 32'h0a8, 32'h173b3b63, 2'h2);
    one_tick(32'h0, 32'h0b8, 32'hff3b3b63, 2'h2);
    one_tick(32'h00003b63, 32'h190, 32'h00003b64, 2'h0);
    for (int s = 0; s < 3; s++) begin
      src_code = (s == 0) ? `SRC_OSC_32K : ((s == 1) ? `SRC_WATCH_XTAL : `SRC_PLL_UNDIV);
      setup(32'h0, 32'h180 | ({30'h0, src_code} << 9));
      for (int p = 0; p < 3; p++) pulse(p, 1);
      rd(a_val, 32'h1, "selected source only");
    end
    // Any 16 or 256 source edges hold exactly one divided tick, whatever the phase
    setup(32'h0, 32'h184);
    pulse(0, 16);
    rd(a_val, 32'h1, "divide by 16");
    setup(32'h0, 32'h188);
    pulse(0, 256);
    rd(a_val, 32'h1, "divide by 256");
    setup(32'hffffff00, 32'h3c0);
    wait_irq();
    rd(a_st, 32'h1, "core wrap status");
    wait_irq();
    wr(a_clr, 32'h0);
    @(posedge clk_i);
    chk_bit(irq_o, 1'b0, "clear drops irq");
    wr(a_ctl, 32'h200);
    bus(1'b0, a_val, 32'h0, hold);
    rd(a_val, hold, "held while disabled");
    chk_bit(hold > 32'hffffff00, 1'b1, "core counted after reload");
    wr(a_msk, 32'h0);
    rd(a_msk, 32'h0, "mask readback");
    setup(32'hffffffff, 32'h180);
    pulse(0, 1);
    chk_bit(irq_o, 1'b0, "masked irq");
    rd(a_st, 32'h1, "masked status");
    rd(a_st, 32'h0, "status read clears");
    wr(a_msk, 32'h3);
    // Prescaler phase is zero here after the last divide-by-one tick
    setup(32'hffffffff, 32'h38f);
    repeat (32700) @(posedge clk_i);
    chk_bit(irq_o, 1'b0, "tick before 32768 clocks");
    wait_irq();
    rd(a_val, 32'h0, "divide by 32768");
    conclude();
  end
endmodule
`default_nettype wire
